// ===== rtl/trip_pkg.sv
/*
  Shared constants of the drive fault trip manager: register offsets, field
  positions, reset values, trip indices and timing counts.
  Assumes a 50 MHz system clock and a 16-bit register port.
*/
package trip_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned CYCLES_PER_MS = CLK_HZ / 1000;
  localparam int unsigned LINK_LOSS_MS = 500;
  localparam int unsigned LINK_LOSS_CYCLES = LINK_LOSS_MS * CYCLES_PER_MS;
  localparam int unsigned CHARGE_WINDOW_MS = 1000;
  localparam int unsigned CHARGE_WINDOW_CYCLES = CHARGE_WINDOW_MS * CYCLES_PER_MS;
  localparam int unsigned DRIVE_OVERLOAD_MS = 60000;
  localparam int unsigned DRIVE_OVERLOAD_CYCLES = DRIVE_OVERLOAD_MS * CYCLES_PER_MS;
  localparam int unsigned MOTOR_THERMAL_MS = 60000;
  localparam int unsigned MOTOR_THERMAL_CYCLES = MOTOR_THERMAL_MS * CYCLES_PER_MS;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_OVERLOAD_ENABLE = 8'h04;
  localparam logic [7:0] REG_OVERLOAD_LEVEL = 8'h08;
  localparam logic [7:0] REG_THERMAL_ENABLE = 8'h0c;
  localparam logic [7:0] REG_PHASE_PROTECT = 8'h10;
  localparam logic [7:0] REG_RATED_CURRENT = 8'h14;
  localparam logic [7:0] REG_BRAKE_CURRENT = 8'h18;
  localparam logic [7:0] REG_RELAY_ONE = 8'h1c;
  localparam logic [7:0] REG_RELAY_TWO = 8'h20;
  localparam logic [7:0] REG_INPUT_CONFIG = 8'h24;
  localparam logic [7:0] REG_WARN_MASK = 8'h28;
  localparam logic [7:0] REG_TRIP_STATUS = 8'h2c;
  localparam logic [7:0] REG_HISTORY = 8'h30;
  localparam logic [7:0] REG_DISPLAY = 8'h34;

  // Field positions
  localparam int CTRL_RESET_BIT = 0;
  localparam int CFG_PNP_BIT = 0;
  localparam int CFG_EXT_A_BIT = 1;
  localparam int CFG_EXT_B_BIT = 2;
  localparam int PHASE_OPEN_BIT = 1;
  localparam int DISP_VALID_BIT = 15;

  // Reset values
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_RATED_CURRENT = 16'h0100;
  localparam logic [15:0] RST_OVERLOAD_LEVEL = 16'h0180;
  localparam logic [15:0] RST_PHASE_PROTECT = 16'h0002;
  localparam logic [15:0] BRAKE_FUNCTION_CODE = 16'h0013;

  // ----------------------------------------------------------------
  // Trip indices and classes (index 0 is highest display priority)
  // ----------------------------------------------------------------
  localparam int NUM_TRIPS = 16;
  localparam int T_CHARGE = 0;
  localparam int T_OVER_CURRENT = 1;
  localparam int T_GROUND = 2;
  localparam int T_OVER_VOLT = 3;
  localparam int T_UNDER_VOLT = 4;
  localparam int T_MOTOR_OVERLOAD = 5;
  localparam int T_MOTOR_THERMAL = 6;
  localparam int T_DRIVE_OVERLOAD = 7;
  localparam int T_PHASE_LOSS = 8;
  localparam int T_OVERHEAT = 9;
  localparam int T_SENSOR_OPEN = 10;
  localparam int T_FAN = 11;
  localparam int T_EXT_CLOSED = 12;
  localparam int T_EXT_OPEN = 13;
  localparam int T_LINK = 14;
  localparam int T_BRAKE = 15;
  localparam logic [15:0] FATAL_MASK = 16'h0001;
  localparam logic [15:0] LEVEL_MASK = 16'h0010;
  localparam logic [15:0] LATCH_MASK = 16'hffee;

endpackage

// ===== rtl/inverse_time_accum.sv
/*
  Inverse-time overload model: an accumulator that rises while the load is
  above its limit and falls while below, flagging when the allowance is spent.
  Assumes the over flag is synchronous to mclk.
*/
`timescale 1ns/1ps
module inverse_time_accum #(
  parameter logic [31:0] LIMIT = 32'h0000_0010
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Model input and result
  input wire logic over,
  output logic expired
);

  logic [31:0] acc;
  wire at_limit = (acc >= LIMIT - 32'h1);

  // Symmetric heat and cool rates keep the model simple
  always_ff @(posedge mclk) begin
    if (rst) begin
      acc <= 32'h0;
      expired <= 1'b0;
    end else begin
      if (over && !at_limit) begin
        acc <= acc + 32'h1;
      end else if (!over && acc != 32'h0) begin
        acc <= acc - 32'h1;
      end
      expired <= over && at_limit;
    end
  end

endmodule

// ===== rtl/trip_priority_select.sv
/*
  Priority selector: picks the highest priority pending trip for display.
  Assumes index 0 is the highest priority.
*/
`timescale 1ns/1ps
module trip_priority_select
  import trip_pkg::*;
(
  // Pending trips
  input wire logic [15:0] pending,
  // Selected trip
  output logic [3:0] code,
  output logic valid
);

  // Scan from lowest to highest priority so the last hit wins
  always_comb begin
    code = 4'h0;
    valid = 1'b0;
    for (int i = NUM_TRIPS - 1; i >= 0; i--) begin
      if (pending[i]) begin
        code = 4'(i);
        valid = 1'b1;
      end
    end
  end

endmodule

// ===== rtl/drive_fault_trip_manager.sv
/*
  Drive fault trip manager top: turns sensed fault flags into level, latch
  and fatal trips, stops the drive or warns, records history and selects
  the trip shown on the display.
  Assumes all inputs are synchronous to mclk and that rst is applied at
  power-up; rst is the only way to clear a fatal trip.
*/
`timescale 1ns/1ps
module drive_fault_trip_manager
  import trip_pkg::*;
#(
  parameter logic [31:0] LINK_LOSS_LIMIT = 32'(LINK_LOSS_CYCLES),
  parameter logic [31:0] CHARGE_WINDOW = 32'(CHARGE_WINDOW_CYCLES),
  parameter logic [31:0] DRIVE_OVERLOAD_LIMIT = 32'(DRIVE_OVERLOAD_CYCLES),
  parameter logic [31:0] MOTOR_THERMAL_LIMIT = 32'(MOTOR_THERMAL_CYCLES)
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // Measurements
  input wire logic [15:0] output_current,
  input wire logic [15:0] motor_load,
  // Sensed fault flags
  input wire logic dc_over_voltage,
  input wire logic dc_under_voltage,
  input wire logic ground_current_high,
  input wire logic motor_heat_over,
  input wire logic phase_open,
  input wire logic drive_load_over,
  input wire logic power_unstable,
  input wire logic charge_fail,
  input wire logic heatsink_hot,
  input wire logic temp_sensor_error,
  input wire logic fan_error,
  input wire logic internal_link_ok,
  input wire logic brake_signal_active,
  // Multi-function terminals and reset terminal
  input wire logic ext_trip_a_pin,
  input wire logic ext_trip_b_pin,
  input wire logic fault_reset_pin,
  // Drive and display outputs
  output logic [15:0] trip_active,
  output logic drive_stop,
  output logic warning_out,
  output logic [3:0] display_code,
  output logic display_valid
);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [15:0] overload_enable_param;
  logic [15:0] overload_level;
  logic [15:0] thermal_enable_param;
  logic [15:0] phase_protect_param;
  logic [15:0] rated_current;
  logic [15:0] brake_release_current_param;
  logic [15:0] relay_one_function;
  logic [15:0] relay_two_function;
  logic [15:0] input_config;
  logic [15:0] warn_mask;
  logic [15:0] history;
  logic soft_reset;

  // Address decode
  wire wr_control = reg_write && (reg_addr == REG_CONTROL);
  wire wr_history = reg_write && (reg_addr == REG_HISTORY);

  // Plain registers; writes to read-only or unmapped offsets are ignored
  always_ff @(posedge mclk) begin
    if (rst) begin
      overload_enable_param <= RST_ZERO;
      overload_level <= RST_OVERLOAD_LEVEL;
      thermal_enable_param <= RST_ZERO;
      phase_protect_param <= RST_PHASE_PROTECT;
      rated_current <= RST_RATED_CURRENT;
      brake_release_current_param <= RST_ZERO;
      relay_one_function <= RST_ZERO;
      relay_two_function <= RST_ZERO;
      input_config <= RST_ZERO;
      warn_mask <= RST_ZERO;
    end else if (reg_write) begin
      unique case (reg_addr)
        REG_OVERLOAD_ENABLE: overload_enable_param <= reg_wdata;
        REG_OVERLOAD_LEVEL: overload_level <= reg_wdata;
        REG_THERMAL_ENABLE: thermal_enable_param <= reg_wdata;
        REG_PHASE_PROTECT: phase_protect_param <= reg_wdata;
        REG_RATED_CURRENT: rated_current <= reg_wdata;
        REG_BRAKE_CURRENT: brake_release_current_param <= reg_wdata;
        REG_RELAY_ONE: relay_one_function <= reg_wdata;
        REG_RELAY_TWO: relay_two_function <= reg_wdata;
        REG_INPUT_CONFIG: input_config <= reg_wdata;
        REG_WARN_MASK: warn_mask <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Reset request from software, one cycle per write
  always_ff @(posedge mclk) begin
    if (rst) begin
      soft_reset <= 1'b0;
    end else begin
      soft_reset <= wr_control && reg_wdata[CTRL_RESET_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Fault condition detection
  // ----------------------------------------------------------------
  logic [31:0] link_lost_count;
  logic [31:0] uv_window;
  logic motor_thermal_expired;
  logic drive_overload_expired;

  // Doubled rating kept at 17 bits so a large rating cannot wrap
  wire [16:0] current_limit = {rated_current, 1'b0};
  wire over_current = {1'b0, output_current} > current_limit;
  wire overload_on = overload_enable_param != RST_ZERO;
  wire motor_overload = overload_on && (motor_load > overload_level);
  wire thermal_on = thermal_enable_param != RST_ZERO;
  wire phase_on = phase_protect_param[PHASE_OPEN_BIT];

  // Terminal closed: PNP sources current (high), NPN sinks to common (low)
  wire pnp_mode = input_config[CFG_PNP_BIT];
  wire ext_a_closed = pnp_mode ? ext_trip_a_pin : ~ext_trip_a_pin;
  wire ext_b_closed = pnp_mode ? ext_trip_b_pin : ~ext_trip_b_pin;
  wire ext_a_cond = input_config[CFG_EXT_A_BIT] && ext_a_closed;
  wire ext_b_cond = input_config[CFG_EXT_B_BIT] && !ext_b_closed;

  // Brake output chosen on either relay
  wire brake_relay = (relay_one_function == BRAKE_FUNCTION_CODE) ||
                     (relay_two_function == BRAKE_FUNCTION_CODE);
  wire brake_cond = brake_relay && brake_signal_active &&
                    (output_current < brake_release_current_param);

  // Link loss counts stop at the limit, so the trip condition stays steady
  wire link_lost = link_lost_count >= LINK_LOSS_LIMIT;
  always_ff @(posedge mclk) begin
    if (rst || internal_link_ok) begin
      link_lost_count <= 32'h0;
    end else if (!link_lost) begin
      link_lost_count <= link_lost_count + 32'h1;
    end
  end

  // Window opened when under-voltage recovers; power dipping and returning
  // inside it is treated as a charging circuit risk
  wire uv_window_open = uv_window != 32'h0;
  wire uv_recovered = trip_active[T_UNDER_VOLT] && !dc_under_voltage;
  always_ff @(posedge mclk) begin
    if (rst) begin
      uv_window <= 32'h0;
    end else if (uv_recovered) begin
      uv_window <= CHARGE_WINDOW;
    end else if (uv_window_open) begin
      uv_window <= uv_window - 32'h1;
    end
  end
  wire flicker = uv_window_open && dc_under_voltage && !trip_active[T_UNDER_VOLT];

  // Inverse-time models
  inverse_time_accum #(
    .LIMIT(MOTOR_THERMAL_LIMIT)
  ) u_motor_thermal (
    .mclk(mclk),
    .rst(rst),
    .over(motor_heat_over && thermal_on),
    .expired(motor_thermal_expired)
  );

  inverse_time_accum #(
    .LIMIT(DRIVE_OVERLOAD_LIMIT)
  ) u_drive_overload (
    .mclk(mclk),
    .rst(rst),
    .over(drive_load_over),
    .expired(drive_overload_expired)
  );

  // Condition vector, one bit per trip
  logic [15:0] cond;
  assign cond[T_CHARGE] = power_unstable || charge_fail || flicker;
  assign cond[T_OVER_CURRENT] = over_current;
  assign cond[T_GROUND] = ground_current_high;
  assign cond[T_OVER_VOLT] = dc_over_voltage;
  assign cond[T_UNDER_VOLT] = dc_under_voltage;
  assign cond[T_MOTOR_OVERLOAD] = motor_overload;
  assign cond[T_MOTOR_THERMAL] = motor_thermal_expired && thermal_on;
  assign cond[T_DRIVE_OVERLOAD] = drive_overload_expired;
  assign cond[T_PHASE_LOSS] = phase_open && phase_on;
  assign cond[T_OVERHEAT] = heatsink_hot;
  assign cond[T_SENSOR_OPEN] = temp_sensor_error;
  assign cond[T_FAN] = fan_error;
  assign cond[T_EXT_CLOSED] = ext_a_cond;
  assign cond[T_EXT_OPEN] = ext_b_cond;
  assign cond[T_LINK] = link_lost;
  assign cond[T_BRAKE] = brake_cond;

  // ----------------------------------------------------------------
  // Trip classes
  // ----------------------------------------------------------------
  // A reset request only drops latch trips; a present condition sets again,
  // so set always wins over the clear
  wire reset_req = soft_reset || fault_reset_pin;
  wire [15:0] keep_mask = reset_req ? FATAL_MASK : (FATAL_MASK | LATCH_MASK);
  wire [15:0] next_trip = cond | (trip_active & keep_mask);

  // Level trips never reach the history
  wire [15:0] new_events = next_trip & ~trip_active & ~LEVEL_MASK;
  wire [15:0] hist_clear = wr_history ? reg_wdata : RST_ZERO;
  wire [15:0] next_history = (history & ~hist_clear) | new_events;

  // Selection for display
  logic [3:0] sel_code;
  logic sel_valid;
  trip_priority_select u_select (
    .pending(next_trip),
    .code(sel_code),
    .valid(sel_valid)
  );

  // Trips masked as warnings keep the drive running
  wire next_stop = |(next_trip & ~warn_mask);
  wire next_warn = |(next_trip & warn_mask);

  always_ff @(posedge mclk) begin
    if (rst) begin
      trip_active <= RST_ZERO;
      history <= RST_ZERO;
      drive_stop <= 1'b0;
      warning_out <= 1'b0;
      display_code <= 4'h0;
      display_valid <= 1'b0;
    end else begin
      trip_active <= next_trip;
      history <= next_history;
      drive_stop <= next_stop;
      warning_out <= next_warn;
      display_code <= sel_code;
      display_valid <= sel_valid;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read data stands one cycle after the strobe, zero otherwise
  logic [15:0] read_mux;
  wire [15:0] display_word = {display_valid, 11'h000, display_code};
  always_comb begin
    read_mux = RST_ZERO;
    unique case (reg_addr)
      REG_OVERLOAD_ENABLE: read_mux = overload_enable_param;
      REG_OVERLOAD_LEVEL: read_mux = overload_level;
      REG_THERMAL_ENABLE: read_mux = thermal_enable_param;
      REG_PHASE_PROTECT: read_mux = phase_protect_param;
      REG_RATED_CURRENT: read_mux = rated_current;
      REG_BRAKE_CURRENT: read_mux = brake_release_current_param;
      REG_RELAY_ONE: read_mux = relay_one_function;
      REG_RELAY_TWO: read_mux = relay_two_function;
      REG_INPUT_CONFIG: read_mux = input_config;
      REG_WARN_MASK: read_mux = warn_mask;
      REG_TRIP_STATUS: read_mux = trip_active;
      REG_HISTORY: read_mux = history;
      REG_DISPLAY: read_mux = display_word;
      default: read_mux = RST_ZERO;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= RST_ZERO;
    end else begin
      reg_rdata <= reg_read ? read_mux : RST_ZERO;
    end
  end

endmodule

// ===== tb/trip_checker_sva.sv
/*
  Checker for the drive fault trip manager: trip classes, display choice
  and read port timing. Assumes it is bound to the top module and that
  rst is synchronous and active high.
*/
`timescale 1ns/1ps
module trip_checker_sva
  import trip_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  // Sensed flags and reset terminal
  input wire logic dc_under_voltage,
  input wire logic fan_error,
  input wire logic fault_reset_pin,
  // Drive and display outputs
  input wire logic [15:0] trip_active,
  input wire logic drive_stop,
  input wire logic warning_out,
  input wire logic [3:0] display_code,
  input wire logic display_valid
);
  // ----------------------------------------
  // Trip behaviour
  // ----------------------------------------
  // One domain, so clock and reset are given once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  level_follow_a: assert property (!$past(rst) |-> trip_active[4] == $past(dc_under_voltage))
    else $error("under-voltage trip does not follow its flag");
  flag_sets_a: assert property (fan_error |=> trip_active[11])
    else $error("fan trip not set the cycle after its flag");
  latch_hold_a: assert property (trip_active[11] && !fault_reset_pin && !reg_write
    && !$past(reg_write) |=> trip_active[11])
    else $error("latched trip dropped without a reset request");
  pin_clear_a: assert property (trip_active[11] && fault_reset_pin && !fan_error
    |=> !trip_active[11])
    else $error("latched trip kept after reset terminal request");
  fatal_hold_a: assert property (trip_active[0] |=> trip_active[0])
    else $error("fatal trip cleared without power-up reset");
  stop_warn_a: assert property ((trip_active != 16'h0) == (drive_stop || warning_out))
    else $error("stop or warning disagrees with active trips");
  disp_valid_a: assert property (display_valid == (trip_active != 16'h0))
    else $error("display valid disagrees with active trips");
  disp_prio_a: assert property (display_valid |-> trip_active[display_code]
    && ((trip_active & ((16'h1 << display_code) - 16'h1)) == 16'h0))
    else $error("display does not show the highest priority trip");
  // ----------------------------------------
  // Read port
  // ----------------------------------------
  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 16'h0)
    else $error("read data not zero outside the answer cycle");
  status_read_a: assert property (reg_read && reg_addr == REG_TRIP_STATUS
    |=> reg_rdata == $past(trip_active))
    else $error("status read differs from active trips");

  // Main scenarios reached
  cover property ($rose(trip_active[0]));
  cover property (trip_active[11] && fault_reset_pin);
  cover property ($countones(trip_active) > 2 && display_valid);
endmodule

bind drive_fault_trip_manager trip_checker_sva u_trip_checker_sva (
  .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .dc_under_voltage(dc_under_voltage),
  .fan_error(fan_error), .fault_reset_pin(fault_reset_pin), .trip_active(trip_active),
  .drive_stop(drive_stop), .warning_out(warning_out), .display_code(display_code),
  .display_valid(display_valid)
);

// ===== tb/tb_top.sv
/*
  Self-checking bench of the drive fault trip manager: level, latch and
  fatal trips, priority, resets and register port.
  Assumes the shortened counts set at the instance below.
*/
`timescale 1ns/1ps
module tb_top
  import trip_pkg::*;
;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [15:0] output_current = 16'h0000;
  logic [15:0] motor_load = 16'h0000;
  logic [15:0] flg = 16'h0000;
  logic link_ok = 1'b1;
  logic brake_on = 1'b0;
  logic ext_a = 1'b1;
  logic ext_b = 1'b1;
  logic pin = 1'b0;
  logic [15:0] reg_rdata, trip_active, r;
  logic drive_stop, warning_out, display_valid;
  logic [3:0] display_code;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  int rated;
  localparam logic [7:0] RA [14] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
    8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h3c};
  localparam logic [15:0] RV [14] = '{16'h0, 16'h0180, 16'h0, 16'h0002, 16'h0100, 16'h0,
    16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
  localparam int LT [6] = '{2, 3, 8, 9, 10, 11};

  // Short counts keep the run brief
  drive_fault_trip_manager #(.LINK_LOSS_LIMIT(32'd10), .CHARGE_WINDOW(32'd20),
    .DRIVE_OVERLOAD_LIMIT(32'd8), .MOTOR_THERMAL_LIMIT(32'd8)) u_drive_fault_trip_manager (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .output_current(output_current), .motor_load(motor_load), .dc_over_voltage(flg[3]),
    .dc_under_voltage(flg[4]), .ground_current_high(flg[2]), .motor_heat_over(flg[6]),
    .phase_open(flg[8]), .drive_load_over(flg[7]), .power_unstable(flg[0]),
    .charge_fail(flg[1]), .heatsink_hot(flg[9]), .temp_sensor_error(flg[10]),
    .fan_error(flg[11]), .internal_link_ok(link_ok), .brake_signal_active(brake_on),
    .ext_trip_a_pin(ext_a), .ext_trip_b_pin(ext_b), .fault_reset_pin(pin),
    .trip_active(trip_active), .drive_stop(drive_stop), .warning_out(warning_out),
    .display_code(display_code), .display_valid(display_valid));

  // Clock and hang guard
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Tasks and helpers
  // ----------------------------------------
  task automatic check16(string name, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic trips(logic [15:0] e);
    #1;
    check16("trip_active", e, trip_active);
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge mclk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask
  task automatic rd_chk(string name, logic [7:0] a, logic [15:0] e);
    @(posedge mclk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1;
    check16(name, e, reg_rdata);
  endtask
  // One-cycle flag pulse; trips are visible right after it ends
  task automatic pulse(logic [15:0] v);
    @(posedge mclk);
    flg <= v;
    @(posedge mclk);
    flg <= 16'h0;
  endtask
  task automatic pin_reset();
    @(posedge mclk);
    pin <= 1'b1;
    @(posedge mclk);
    pin <= 1'b0;
  endtask
  task automatic apply_reset(int n);
    @(posedge mclk);
    rst <= 1'b1;
    tick(n);
    rst <= 1'b0;
  endtask
  function automatic logic [15:0] first_set(logic [15:0] v);
    first_set = 16'h0;
    for (int i = 15; i >= 0; i--) if (v[i]) first_set = 16'(i);
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(19922));
    tick(10);
    rst <= 1'b0;
    wr(REG_TRIP_STATUS, 16'($urandom));
    wr(8'h3c, 16'($urandom));
    foreach (RA[i]) rd_chk("register", RA[i], RV[i]);
    $display("test registers done");
    // Level trip, then its return inside the charge window
    @(posedge mclk);
    flg <= 16'h0010;
    pulse(16'h0010); trips(16'h0010);
    tick(1); trips(16'h0000);
    rd_chk("history", REG_HISTORY, 16'h0000);
    pulse(16'h0010); tick(2); trips(16'h0001);
    pin_reset(); trips(16'h0001);
    wr(REG_CONTROL, 16'h0001); tick(2); trips(16'h0001);
    apply_reset(2); trips(16'h0000);
    pulse(16'h0001); trips(16'h0001);
    apply_reset(2); pulse(16'h0002); trips(16'h0001);
    apply_reset(2);
    $display("test level and fatal done");
    // Latch trips cleared alternately by register and by terminal
    wr(REG_WARN_MASK, 16'h0200);
    foreach (LT[i]) begin
      r = 16'h1 << LT[i];
      pulse(r); trips(r);
      check16("stop_warn", (LT[i] == 9) ? 16'h2 : 16'h1, {14'h0, warning_out, drive_stop});
      check16("display", 16'h8000 | 16'(LT[i]), {display_valid, 11'h0, display_code});
      tick(3); trips(r);
      rd_chk("history", REG_HISTORY, r);
      wr(REG_HISTORY, 16'hffff);
      if (i % 2) begin
        wr(REG_CONTROL, 16'h0001);
        tick(2);
      end else pin_reset();
      trips(16'h0000);
    end
    @(posedge mclk);
    flg <= 16'h0800;
    pin_reset(); trips(16'h0800);
    @(posedge mclk);
    flg <= 16'h0000;
    pin_reset(); trips(16'h0000);
    repeat (6) begin
      r = (16'($urandom) & 16'h010c) | 16'h0e00;
      pulse(r); trips(r);
      check16("display", 16'h8000 | first_set(r), {display_valid, 11'h0, display_code});
      pin_reset(); trips(16'h0000);
    end
    wr(REG_PHASE_PROTECT, 16'h0000);
    pulse(16'h0100); trips(16'h0000);
    wr(REG_PHASE_PROTECT, 16'h0002);
    $display("test latch and priority done");
    // Current and load thresholds
    rated = $urandom_range(16'h3fff, 16'h0010);
    wr(REG_RATED_CURRENT, 16'(rated));
    @(posedge mclk);
    output_current <= 16'(2 * rated);
    tick(2); trips(16'h0000);
    @(posedge mclk);
    output_current <= 16'(2 * rated + 1);
    tick(1); trips(16'h0002);
    @(posedge mclk);
    output_current <= 16'h0;
    pin_reset(); trips(16'h0000);
    @(posedge mclk);
    motor_load <= 16'hffff;
    tick(2); trips(16'h0000);
    @(posedge mclk);
    motor_load <= 16'h0180;
    wr(REG_OVERLOAD_ENABLE, 16'h0001); tick(2); trips(16'h0000);
    @(posedge mclk);
    motor_load <= 16'h0181;
    tick(1); trips(16'h0020);
    @(posedge mclk);
    motor_load <= 16'h0;
    pin_reset(); trips(16'h0000);
    $display("test thresholds done");
    // Inverse-time models and lost link
    @(posedge mclk);
    flg <= 16'h0080;
    tick(3); trips(16'h0000);
    tick(9); trips(16'h0080);
    @(posedge mclk);
    flg <= 16'h0040;
    tick(12); trips(16'h0080);
    wr(REG_THERMAL_ENABLE, 16'h0001); tick(10); trips(16'h00c0);
    @(posedge mclk);
    flg <= 16'h0;
    link_ok <= 1'b0;
    tick(9); trips(16'h00c0);
    tick(3); trips(16'h40c0);
    @(posedge mclk);
    link_ok <= 1'b1;
    pin_reset(); trips(16'h0000);
    wr(REG_THERMAL_ENABLE, 16'h0000);
    $display("test timed trips done");
    // External terminals and brake supervision
    wr(REG_INPUT_CONFIG, 16'h0002);
    @(posedge mclk);
    ext_a <= 1'b0;
    @(posedge mclk);
    ext_a <= 1'b1;
    trips(16'h1000);
    pin_reset();
    wr(REG_INPUT_CONFIG, 16'h0005);
    @(posedge mclk);
    ext_b <= 1'b0;
    @(posedge mclk);
    ext_b <= 1'b1;
    trips(16'h2000);
    pin_reset();
    wr(REG_INPUT_CONFIG, 16'h0000);
    wr(REG_RELAY_ONE, BRAKE_FUNCTION_CODE);
    wr(REG_BRAKE_CURRENT, 16'h0050);
    @(posedge mclk);
    output_current <= 16'h0060;
    brake_on <= 1'b1;
    tick(2); trips(16'h0000);
    @(posedge mclk);
    output_current <= 16'h0040;
    tick(1); trips(16'h8000);
    @(posedge mclk);
    brake_on <= 1'b0;
    pin_reset(); trips(16'h0000);
    $display("test terminals and brake done");
    give_verdict();
  end
endmodule
